//--- rtl/mlt_pkg.sv
// What this block does
// - The upper band limit is the level plus half the hysteresis, the lower is the level minus half.
// - A rising trigger fires only when the signal, once below the lower limit, rises past the upper.
// - A falling trigger fires only when the signal, once above the upper limit, falls past the lower.
// - Current, voltage and aux voltmeter input each own a level and a hysteresis, all reset to zero.
// - Each measured signal offers rising, falling or either slope, rising after reset.
// - With either slope selected, both a rising and a falling crossing make a measurement trigger; aux, with its count fixed at 1, gets only the first.
// - The aux voltmeter input has its own slope choice, independent of current and voltage.
// - The trigger source is the bus command or the internal crossing, internal after reset.
// - With the bus source, a trigger command or a group execute trigger is the measurement trigger.
// - Sequence 1 alias accepts only the output-change name and sequence 2 only the measurement name.
// - Reading either alias returns the name currently bound to that sequence.
// - Current and voltage trigger counts run 1 to 100, reset to 1, re-arming until the count is used.
// - Every measurement trigger is ignored while the trigger system is not initiated.
package mlt_pkg;
   localparam int MLT_DATA_W = 16;
   localparam int MLT_CNT_W = 7;
   localparam int MLT_NCH = 3;
   localparam int MLT_ADDR_W = 8;
   localparam logic [6:0] MLT_CNT_MIN = 7'h01;
   localparam logic [6:0] MLT_CNT_MAX = 7'h64;
   localparam logic [6:0] MLT_CNT_RST = 7'h01;
   localparam logic [6:0] MLT_AUX_CNT = 7'h01;
   localparam logic [15:0] MLT_LEV_RST = 16'h0000;
   localparam logic [15:0] MLT_HYST_RST = 16'h0000;
   localparam logic [7:0] MLT_OFF_CTRL = 8'h00;
   localparam logic [7:0] MLT_OFF_CMD = 8'h04;
   localparam logic [7:0] MLT_OFF_SLOPE = 8'h08;
   localparam logic [7:0] MLT_OFF_COUNT = 8'h0C;
   localparam logic [7:0] MLT_OFF_LEV_BASE = 8'h10;
   localparam logic [7:0] MLT_OFF_HYST_BASE = 8'h14;
   localparam logic [7:0] MLT_CH_STRIDE = 8'h08;
   localparam logic [7:0] MLT_OFF_ALIAS = 8'h28;
   localparam logic [7:0] MLT_OFF_STATUS = 8'h2C;
   localparam int MLT_CTRL_SRC = 0;
   localparam int MLT_CTRL_FUNC = 1;
   localparam int MLT_CMD_INIT = 0;
   localparam int MLT_CMD_ABORT = 1;
   localparam int MLT_CMD_TRG = 2;
   localparam int MLT_CMD_GET = 3;
   localparam int MLT_SLOPE_FW = 2;
   localparam int MLT_COUNT_CURR = 0;
   localparam int MLT_COUNT_VOLT = 8;
   localparam int MLT_ALIAS_SEQ1 = 0;
   localparam int MLT_ALIAS_SEQ2 = 1;
   localparam int MLT_STAT_INIT = 0;
   localparam int MLT_STAT_REM = 8;
   localparam logic [1:0] MLT_RESP_OKAY = 2'h0;
   localparam logic [1:0] MLT_RESP_SLVERR = 2'h2;
   typedef enum logic {MLT_SRC_INT = 1'b0, MLT_SRC_BUS = 1'b1} mlt_src_e;
   typedef enum logic [1:0] {
      MLT_CH_CURR = 2'b00, MLT_CH_VOLT = 2'b01, MLT_CH_AUX = 2'b10
   } mlt_chan_e;
   typedef enum logic [1:0] {
      MLT_SLOPE_POS = 2'b00, MLT_SLOPE_NEG = 2'b01, MLT_SLOPE_EITHER = 2'b10
   } mlt_slope_e;
   typedef enum logic {MLT_NAME_OUTCHG = 1'b0, MLT_NAME_MEAS = 1'b1} mlt_name_e;
   typedef enum logic {MLT_ACQ_IDLE = 1'b0, MLT_ACQ_ARMED = 1'b1} mlt_acq_e;
   typedef struct packed {
      logic valid;
      logic [MLT_DATA_W-1:0] value;
   } mlt_sample_s;
endpackage

//--- rtl/mlt_band_det.sv
`timescale 1ns/1ps
module mlt_band_det import mlt_pkg::*; #(
   parameter int DATA_W = MLT_DATA_W
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire logic [DATA_W-1:0] i_value,
   input wire logic [DATA_W-1:0] i_level,
   input wire logic [DATA_W-1:0] i_hyst,
   input wire mlt_slope_e i_slope,
   output logic o_trig
);
   if (DATA_W < 2) begin : g_chk
      $error("DATA_W below 2");
   end
   logic signed [DATA_W+1:0] val, half, upper, lower;
   logic seen_below, seen_above;
   assign val = $signed({2'b00, i_value});
   assign half = $signed({3'b000, i_hyst[DATA_W-1:1]});
   assign upper = $signed({2'b00, i_level}) + half;
   assign lower = $signed({2'b00, i_level}) - half;
   wire above = val > upper;
   wire below = val < lower;
   wire rise = i_valid & seen_below & above;
   wire fall = i_valid & seen_above & below;
   wire want_rise = i_slope != MLT_SLOPE_NEG;
   wire want_fall = i_slope != MLT_SLOPE_POS;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seen_below <= 1'b0;
         seen_above <= 1'b0;
         o_trig <= 1'b0;
      end else begin
         if (i_valid) begin
            seen_below <= below | (seen_below & ~above);
            seen_above <= above | (seen_above & ~below);
         end
         o_trig <= (rise & want_rise) | (fall & want_fall);
      end
   end
endmodule

//--- rtl/mlt_acq_ctl.sv
`timescale 1ns/1ps
module mlt_acq_ctl import mlt_pkg::*; #(
   parameter int CNT_W = MLT_CNT_W
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_init,
   input wire logic i_abort,
   input wire logic i_trig,
   input wire logic [CNT_W-1:0] i_count,
   output logic o_initiated,
   output logic o_meas_trig,
   output logic [CNT_W-1:0] o_remain
);
   if ((2 ** CNT_W) <= int'(MLT_CNT_MAX)) begin : g_chk
      $error("CNT_W too narrow for count");
   end
   mlt_acq_e state;
   wire armed = state == MLT_ACQ_ARMED;
   wire fire = armed & ~i_abort & i_trig;
   wire last = o_remain == CNT_W'(1);
   assign o_initiated = armed;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= MLT_ACQ_IDLE;
         o_remain <= '0;
         o_meas_trig <= 1'b0;
      end else begin
         o_meas_trig <= fire;
         unique case (state)
            MLT_ACQ_IDLE: begin
               if (i_init & ~i_abort) begin
                  state <= MLT_ACQ_ARMED;
                  o_remain <= i_count;
               end
            end
            MLT_ACQ_ARMED: begin
               if (i_abort) begin
                  state <= MLT_ACQ_IDLE;
                  o_remain <= '0;
               end else if (fire) begin
                  o_remain <= o_remain - CNT_W'(1);
                  if (last) begin
                     state <= MLT_ACQ_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule

//--- rtl/mlt_top.sv
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module mlt_top import mlt_pkg::*; #(
   parameter int DATA_W = MLT_DATA_W
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [MLT_ADDR_W-1:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [MLT_ADDR_W-1:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   input wire mlt_sample_s I_SAMPLE_CURR,
   input wire mlt_sample_s I_SAMPLE_VOLT,
   input wire mlt_sample_s I_SAMPLE_AUX,
   output logic O_MEAS_TRIG,
   output logic O_INITIATED
);

   if (DATA_W != MLT_DATA_W) begin : g_chk
      $error("DATA_W must match sample width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte lane merge

   function automatic logic [31:0] wmerge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [31:0] mask
   );
      wmerge = (old & ~mask) | (data & mask);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   mlt_src_e src;
   mlt_chan_e func;
   logic [MLT_NCH*MLT_SLOPE_FW-1:0] slope_reg;
   logic [MLT_CNT_W-1:0] cnt_curr;
   logic [MLT_CNT_W-1:0] cnt_volt;
   mlt_name_e alias1;
   mlt_name_e alias2;
   logic [DATA_W-1:0] level [MLT_NCH];
   logic [DATA_W-1:0] hyst [MLT_NCH];
   logic trig_ch [MLT_NCH];
   mlt_sample_s smp [MLT_NCH];
   logic [MLT_CNT_W-1:0] remain;
   logic initiated;

   assign smp[0] = I_SAMPLE_CURR;
   assign smp[1] = I_SAMPLE_VOLT;
   assign smp[2] = I_SAMPLE_AUX;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel

   logic aw_held;
   logic w_held;
   logic [MLT_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire aw_fire = I_AWVALID & O_AWREADY;
   wire w_fire = I_WVALID & O_WREADY;
   wire do_wr = aw_held & w_held & ~O_BVALID;
   wire next_aw_held = (aw_held & ~do_wr) | aw_fire;
   wire next_w_held = (w_held & ~do_wr) | w_fire;
   wire next_bvalid = do_wr | (O_BVALID & ~I_BREADY);
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   ////////////////////////////////////////////////////////////////////////////
   // Write decode

   wire is_ctrl = aw_addr == MLT_OFF_CTRL;
   wire is_cmd = aw_addr == MLT_OFF_CMD;
   wire is_slope = aw_addr == MLT_OFF_SLOPE;
   wire is_count = aw_addr == MLT_OFF_COUNT;
   wire is_alias = aw_addr == MLT_OFF_ALIAS;

   ////////////////////////////////////////////////////////////////////////////
   // Register images

   wire [31:0] ctrl_cur = {29'h0, func, src};
   wire [31:0] slope_cur = {26'h0, slope_reg};
   wire [31:0] count_cur = {17'h0, cnt_volt, 1'b0, cnt_curr};
   wire [31:0] alias_cur = {30'h0, alias2, alias1};
   wire [31:0] stat_cur = {17'h0, remain, 7'h00, initiated};

   wire [31:0] ctrl_new = wmerge(ctrl_cur, w_data, wmask);
   wire [31:0] slope_new = wmerge(slope_cur, w_data, wmask);
   wire [31:0] count_new = wmerge(count_cur, w_data, wmask);
   wire [31:0] alias_new = wmerge(alias_cur, w_data, wmask);
   wire [31:0] cmd_new = w_data & wmask;

   wire [1:0] func_new = ctrl_new[MLT_CTRL_FUNC +: 2];
   wire [MLT_CNT_W-1:0] cc_new = count_new[MLT_COUNT_CURR +: MLT_CNT_W];
   wire [MLT_CNT_W-1:0] cv_new = count_new[MLT_COUNT_VOLT +: MLT_CNT_W];

   wire ctrl_ok = func_new != 2'b11;
   wire slope_ok = (slope_new[1:0] != 2'b11) & (slope_new[3:2] != 2'b11)
      & (slope_new[5:4] != 2'b11);
   wire cc_ok = (cc_new >= MLT_CNT_MIN) & (cc_new <= MLT_CNT_MAX);
   wire cv_ok = (cv_new >= MLT_CNT_MIN) & (cv_new <= MLT_CNT_MAX);
   wire alias_ok = (alias_new[MLT_ALIAS_SEQ1] == MLT_NAME_OUTCHG)
      & (alias_new[MLT_ALIAS_SEQ2] == MLT_NAME_MEAS);

   logic ch_whit [MLT_NCH+1];
   assign ch_whit[0] = 1'b0;

   wire w_known = is_ctrl | is_cmd | is_slope | is_count | is_alias | ch_whit[MLT_NCH];
   wire w_bad = (is_ctrl & ~ctrl_ok) | (is_slope & ~slope_ok)
      | (is_count & ~(cc_ok & cv_ok)) | (is_alias & ~alias_ok);
   wire wr_ok = w_known & ~w_bad;
   wire wr_go = do_wr & wr_ok;
   wire [1:0] next_bresp = wr_ok ? MLT_RESP_OKAY : MLT_RESP_SLVERR;

   ////////////////////////////////////////////////////////////////////////////
   // Write enables

   wire wr_ctrl = wr_go & is_ctrl;
   wire wr_slope = wr_go & is_slope;
   wire wr_count = wr_go & is_count;
   wire wr_alias = wr_go & is_alias;

   ////////////////////////////////////////////////////////////////////////////
   // Write handshake and capture

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         O_AWREADY <= 1'b0;
         O_WREADY <= 1'b0;
         O_BVALID <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         O_AWREADY <= ~next_aw_held;
         O_WREADY <= ~next_w_held;
         O_BVALID <= next_bvalid;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         aw_addr <= '0;
      end else if (aw_fire) begin
         aw_addr <= I_AWADDR;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         w_data <= '0;
         w_strb <= '0;
      end else if (w_fire) begin
         w_data <= I_WDATA;
         w_strb <= I_WSTRB;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_BRESP <= MLT_RESP_OKAY;
      end else if (do_wr) begin
         O_BRESP <= next_bresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings registers

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         src <= MLT_SRC_INT;
         func <= MLT_CH_CURR;
      end else if (wr_ctrl) begin
         src <= mlt_src_e'(ctrl_new[MLT_CTRL_SRC]);
         func <= mlt_chan_e'(func_new);
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         slope_reg <= {MLT_SLOPE_POS, MLT_SLOPE_POS, MLT_SLOPE_POS};
      end else if (wr_slope) begin
         slope_reg <= slope_new[MLT_NCH*MLT_SLOPE_FW-1:0];
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cnt_curr <= MLT_CNT_RST;
         cnt_volt <= MLT_CNT_RST;
      end else if (wr_count) begin
         cnt_curr <= cc_new;
         cnt_volt <= cv_new;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         alias1 <= MLT_NAME_OUTCHG;
         alias2 <= MLT_NAME_MEAS;
      end else if (wr_alias) begin
         alias1 <= mlt_name_e'(alias_new[MLT_ALIAS_SEQ1]);
         alias2 <= mlt_name_e'(alias_new[MLT_ALIAS_SEQ2]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per channel level, hysteresis and band detector

   logic [31:0] ch_rd [MLT_NCH+1];
   logic ch_rhit [MLT_NCH+1];
   assign ch_rd[0] = 32'h0000_0000;
   assign ch_rhit[0] = 1'b0;

   for (genvar k = 0; k < MLT_NCH; k++) begin : g_ch
      localparam logic [7:0] LEV_OFF = 8'(MLT_OFF_LEV_BASE + k * MLT_CH_STRIDE);
      localparam logic [7:0] HYST_OFF = 8'(MLT_OFF_HYST_BASE + k * MLT_CH_STRIDE);
      wire [31:0] lev_cur = {{(32-DATA_W){1'b0}}, level[k]};
      wire [31:0] hyst_cur = {{(32-DATA_W){1'b0}}, hyst[k]};
      wire [31:0] lev_new = wmerge(lev_cur, w_data, wmask);
      wire [31:0] hyst_new = wmerge(hyst_cur, w_data, wmask);
      wire w_lev = aw_addr == LEV_OFF;
      wire w_hyst = aw_addr == HYST_OFF;
      wire r_lev = I_ARADDR == LEV_OFF;
      wire r_hyst = I_ARADDR == HYST_OFF;
      assign ch_whit[k+1] = ch_whit[k] | w_lev | w_hyst;
      assign ch_rhit[k+1] = ch_rhit[k] | r_lev | r_hyst;
      assign ch_rd[k+1] = ch_rd[k] | (r_lev ? lev_cur : 32'h0000_0000)
         | (r_hyst ? hyst_cur : 32'h0000_0000);
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
         if (!I_RST_B) begin
            level[k] <= MLT_LEV_RST;
            hyst[k] <= MLT_HYST_RST;
         end else begin
            if (wr_go & w_lev) begin
               level[k] <= lev_new[DATA_W-1:0];
            end
            if (wr_go & w_hyst) begin
               hyst[k] <= hyst_new[DATA_W-1:0];
            end
         end
      end
      mlt_band_det #(
         .DATA_W(DATA_W)
      ) u_det (
         .i_clk(I_CLK),
         .i_rst_b(I_RST_B),
         .i_valid(smp[k].valid),
         .i_value(smp[k].value),
         .i_level(level[k]),
         .i_hyst(hyst[k]),
         .i_slope(mlt_slope_e'(slope_reg[k*MLT_SLOPE_FW +: MLT_SLOPE_FW])),
         .o_trig(trig_ch[k])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger source and sequencing

   wire cmd_go = wr_go & is_cmd;
   wire do_init = cmd_go & cmd_new[MLT_CMD_INIT];
   wire do_abort = cmd_go & cmd_new[MLT_CMD_ABORT];
   wire bus_trg = cmd_go & (cmd_new[MLT_CMD_TRG] | cmd_new[MLT_CMD_GET]);
   wire sel_curr = func == MLT_CH_CURR;
   wire sel_volt = func == MLT_CH_VOLT;
   wire int_trg = sel_curr ? trig_ch[0] : sel_volt ? trig_ch[1] : trig_ch[2];
   wire acq_trg = (src == MLT_SRC_BUS) ? bus_trg : int_trg;
   wire [MLT_CNT_W-1:0] count_sel = sel_curr ? cnt_curr
      : sel_volt ? cnt_volt : MLT_AUX_CNT;

   mlt_acq_ctl #(
      .CNT_W(MLT_CNT_W)
   ) u_acq (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_init(do_init),
      .i_abort(do_abort),
      .i_trig(acq_trg),
      .i_count(count_sel),
      .o_initiated(initiated),
      .o_meas_trig(O_MEAS_TRIG),
      .o_remain(remain)
   );

   assign O_INITIATED = initiated;

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   wire ar_fire = I_ARVALID & O_ARREADY;
   wire next_rvalid = ar_fire | (O_RVALID & ~I_RREADY);
   wire r_ctrl = I_ARADDR == MLT_OFF_CTRL;
   wire r_cmd = I_ARADDR == MLT_OFF_CMD;
   wire r_slope = I_ARADDR == MLT_OFF_SLOPE;
   wire r_count = I_ARADDR == MLT_OFF_COUNT;
   wire r_alias = I_ARADDR == MLT_OFF_ALIAS;
   wire r_stat = I_ARADDR == MLT_OFF_STATUS;
   wire r_hit = r_ctrl | r_cmd | r_slope | r_count | r_alias | r_stat | ch_rhit[MLT_NCH];
   wire [31:0] rd_ctrl = r_ctrl ? ctrl_cur : 32'h0000_0000;
   wire [31:0] rd_slope = r_slope ? slope_cur : 32'h0000_0000;
   wire [31:0] rd_count = r_count ? count_cur : 32'h0000_0000;
   wire [31:0] rd_alias = r_alias ? alias_cur : 32'h0000_0000;
   wire [31:0] rd_stat = r_stat ? stat_cur : 32'h0000_0000;
   wire [31:0] rd_data = rd_ctrl | rd_slope | rd_count | rd_alias | rd_stat | ch_rd[MLT_NCH];
   wire [31:0] next_rdata = r_hit ? rd_data : 32'h0000_0000;
   wire [1:0] next_rresp = r_hit ? MLT_RESP_OKAY : MLT_RESP_SLVERR;

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b0;
      end else begin
         O_ARREADY <= ~next_rvalid;
         O_RVALID <= next_rvalid;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= 32'h0000_0000;
         O_RRESP <= MLT_RESP_OKAY;
      end else if (ar_fire) begin
         O_RDATA <= next_rdata;
         O_RRESP <= next_rresp;
      end
   end

endmodule

//--- test/mlt_top_properties.sv
`timescale 1ns/1ps
module mlt_top_properties (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_BREADY,
   input wire logic I_RREADY,
   input wire logic O_AWREADY,
   input wire logic O_WREADY,
   input wire logic O_ARREADY,
   input wire logic O_BVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic O_MEAS_TRIG,
   input wire logic O_INITIATED
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);
   ////////////////////////////////////////
   AST_ONE_PULSE: assert property (O_MEAS_TRIG |=> !O_MEAS_TRIG)
      else $error("trigger pulse longer than one cycle");
   AST_NEED_INIT: assert property (O_MEAS_TRIG |-> $past(O_INITIATED))
      else $error("trigger while not initiated");
   AST_RST_IDLE: assert property ($rose(I_RST_B) |-> !O_INITIATED && !O_MEAS_TRIG)
      else $error("not idle after reset");
   AST_INIT_BY_WRITE: assert property ($rose(O_INITIATED) |-> $rose(O_BVALID))
      else $error("initiated without a command write");
   AST_END_CAUSE: assert property ($fell(O_INITIATED) |->
      ($rose(O_BVALID) || O_MEAS_TRIG || $past(O_MEAS_TRIG)) or (##1 O_MEAS_TRIG))
      else $error("idle without trigger or abort");
   AST_BRESP_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   AST_RDATA_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped early");
   AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
      else $error("read address taken while data pending");
   AST_READY_UP: assert property ($rose(I_RST_B) |=> O_AWREADY && O_WREADY && O_ARREADY)
      else $error("bus not ready after reset");
   COV_TRIG: cover property (O_MEAS_TRIG);
   COV_DONE: cover property ($fell(O_INITIATED));
   COV_ERR: cover property (O_BVALID && O_BRESP == 2'h2);
endmodule
bind mlt_top mlt_top_properties mlt_top_properties_i (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
   .I_BREADY(I_BREADY), .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY),
   .O_ARREADY(O_ARREADY), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID),
   .O_RDATA(O_RDATA), .O_MEAS_TRIG(O_MEAS_TRIG), .O_INITIATED(O_INITIATED));

//--- test/mlt_sample_src.sv
`timescale 1ns/1ps
module mlt_sample_src import mlt_pkg::*; (
   input wire logic i_clk,
   output mlt_sample_s o_sample
);
   initial o_sample = '0;
   // One-cycle strobe; value inverted once the strobe drops
   task automatic put(input logic [MLT_DATA_W-1:0] v);
      o_sample <= {1'b1, v};
      @(posedge i_clk);
      o_sample <= {1'b0, ~v};
   endtask
endmodule

//--- test/mlt_top_tb.sv
`timescale 1ns/1ps
module mlt_top_tb import mlt_pkg::*;;
   logic clk, rst_b, awv, wv, bready, arv, rready;
   logic awready, wready, bvalid, arready, rvalid, mtrig, initd;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, e2;
   logic [33:0] e34;
   logic [15:0] v;
   mlt_sample_s s_cur, s_vol, s_aux;
   int errors = 0;
   int n_checks = 0;
   int seed = 3266;
   int n;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   bit tq[$];
   mlt_top mlt_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv), .O_AWREADY(awready),
      .I_AWADDR(awaddr), .I_WVALID(wv), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF),
      .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arv),
      .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
      .O_RDATA(rdata), .O_RRESP(rresp), .I_SAMPLE_CURR(s_cur), .I_SAMPLE_VOLT(s_vol),
      .I_SAMPLE_AUX(s_aux), .O_MEAS_TRIG(mtrig), .O_INITIATED(initd));
   mlt_sample_src src_cur_i (.i_clk(clk), .o_sample(s_cur));
   mlt_sample_src src_vol_i (.i_clk(clk), .o_sample(s_vol));
   mlt_sample_src src_aux_i (.i_clk(clk), .o_sample(s_aux));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic complete_run;
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic miss(input string m);
      errors++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic tick(inout int k);
      @(posedge clk);
      k++;
      if (k > 60) begin
         miss("timeout");
         complete_run;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      bit pa, pd;
      int k;
      pa = 1;
      pd = 1;
      k = 0;
      bq.push_back(r);
      awv <= 1;
      wv <= 1;
      awaddr <= a;
      wdata <= d;
      while (pa || pd) begin
         tick(k);
         if (awready && pa) begin
            pa = 0;
            awv <= 0;
         end
         if (wready && pd) begin
            pd = 0;
            wv <= 0;
         end
      end
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      bready <= 1;
      do tick(k); while (!bvalid);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      int k;
      k = 0;
      rq.push_back({r, d});
      arv <= 1;
      araddr <= a;
      do tick(k); while (!arready);
      arv <= 0;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
      rready <= 1;
      do tick(k); while (!rvalid);
      rready <= 0;
   endtask
   task automatic smp(input int ch, input logic [15:0] x);
      case (ch)
         0: src_cur_i.put(x);
         1: src_vol_i.put(x);
         default: src_aux_i.put(x);
      endcase
      repeat (3) @(posedge clk);
   endtask
   task automatic expect_trigs(input int k);
      repeat (k) tq.push_back(1'b1);
   endtask
   task automatic chk_empty;
      repeat (4) @(posedge clk);
      n_checks++;
      if (tq.size() != 0) miss("missing trigger");
      tq.delete();
   endtask
   ////////////////////////////////////////
   always @(posedge clk) begin
      if (bvalid && bready) begin
         n_checks++;
         e2 = (bq.size() != 0) ? bq.pop_front() : 2'bxx;
         if (bresp !== e2) miss("write response");
      end
      if (rvalid && rready) begin
         n_checks++;
         e34 = (rq.size() != 0) ? rq.pop_front() : 'x;
         if ({rresp, rdata} !== e34) miss("read data");
      end
      if (mtrig) begin
         n_checks++;
         if (tq.size() == 0) miss("unexpected trigger");
         else void'(tq.pop_front());
      end
   end
   initial begin
      {rst_b, awv, wv, bready, arv, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (3) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      rd(MLT_OFF_CTRL, 32'h0);
      rd(MLT_OFF_SLOPE, 32'h0);
      rd(MLT_OFF_COUNT, 32'h0101);
      for (int i = 0; i < 6; i++) rd(MLT_OFF_LEV_BASE + 8'(4 * i), 32'h0);
      rd(MLT_OFF_ALIAS, 32'h2);
      rd(MLT_OFF_STATUS, 32'h0);
      rd(8'h30, 32'h0, MLT_RESP_SLVERR);
      wr(MLT_OFF_CTRL, 32'h6, MLT_RESP_SLVERR);
      wr(MLT_OFF_SLOPE, 32'h30, MLT_RESP_SLVERR);
      wr(MLT_OFF_COUNT, 32'h0100, MLT_RESP_SLVERR);
      wr(MLT_OFF_COUNT, 32'h6501, MLT_RESP_SLVERR);
      wr(MLT_OFF_ALIAS, 32'h1, MLT_RESP_SLVERR);
      wr(MLT_OFF_ALIAS, 32'h2);
      wr(MLT_OFF_STATUS, 32'h0, MLT_RESP_SLVERR);
      wr(MLT_OFF_COUNT, 32'h6464);
      rd(MLT_OFF_COUNT, 32'h6464);
      rd(MLT_OFF_ALIAS, 32'h2);
      v = 16'($random(seed));
      wr(MLT_OFF_LEV_BASE, {16'h0, v});
      rd(MLT_OFF_LEV_BASE, {16'h0, v});
      wr(MLT_OFF_COUNT, 32'h0202);
      for (int ch = 0; ch < 3; ch++) begin
         wr(MLT_OFF_CTRL, 32'(ch << 1));
         wr(MLT_OFF_LEV_BASE + 8'(8 * ch), 32'h64);
         wr(MLT_OFF_HYST_BASE + 8'(8 * ch), 32'h4);
         for (int sl = 0; sl < 3; sl++) begin
            wr(MLT_OFF_SLOPE, 32'(sl << (2 * ch)));
            smp(ch, 16'h0067);
            smp(ch, 16'h0061);
            wr(MLT_OFF_CMD, 32'h1);
            n = int'(sl != 1) + int'(sl != 0);
            if (ch == 2 && n > 1) n = 1;
            expect_trigs(n);
            smp(ch, 16'h0066);
            smp(ch, 16'h0067);
            smp(ch, 16'h0062);
            smp(ch, 16'h0061);
            wr(MLT_OFF_CMD, 32'h2);
            chk_empty;
         end
      end
      wr(MLT_OFF_CTRL, 32'h1);
      wr(MLT_OFF_CMD, 32'h4);
      wr(MLT_OFF_CMD, 32'h1);
      rd(MLT_OFF_STATUS, 32'h0201);
      n_checks++;
      if (initd !== 1'b1) miss("initiated flag low");
      expect_trigs(1);
      wr(MLT_OFF_CMD, 32'h4);
      smp(0, 16'h0067);
      smp(0, 16'h0061);
      rd(MLT_OFF_STATUS, 32'h0101);
      expect_trigs(1);
      wr(MLT_OFF_CMD, 32'h8);
      rd(MLT_OFF_STATUS, 32'h0);
      wr(MLT_OFF_CMD, 32'h1);
      wr(MLT_OFF_CMD, 32'h6);
      rd(MLT_OFF_STATUS, 32'h0);
      n_checks++;
      if (initd !== 1'b0) miss("initiated flag high");
      chk_empty;
      complete_run;
   end
endmodule
